//--- design/lpm_pkg.sv
/*
 * Package for the low-power mode controller: types and constants.
 * Assumes one clock and a synchronous active-high reset.
 */
package lpm_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned OSC_SETTLE_NS   = 1000;
  localparam int unsigned OSC_SETTLE_CYC  =
    (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIV_W           = 4;
  localparam int unsigned NUM_CLK         = 6;
  localparam int unsigned CLK_CORE        = 0;
  localparam int unsigned CLK_FAST_PERIPH = 1;
  localparam int unsigned CLK_PERIPH      = 2;
  localparam int unsigned CLK_CONVERTER   = 3;
  localparam int unsigned CLK_EXT_BUS     = 4;
  localparam int unsigned CLK_FLASH_IF    = 5;
  localparam logic [DIV_W-1:0] DIV_RST    = 4'h0;
  localparam logic [31:0] RAM_BASE        = 32'h0000_0000;
  localparam logic [31:0] RAM_LAST        = 32'h0000_ffff;

  typedef enum logic [1:0] {
    LPM_OP_HIGH,
    LPM_OP_MIDDLE,
    LPM_OP_LOW
  } lpm_op_mode_t;

  typedef enum {
    LPM_RUN,
    LPM_SLEEP,
    LPM_DEEP_SLEEP,
    LPM_STANDBY,
    LPM_OSC_WAKE,
    LPM_CLK_WAKE
  } lpm_state_t;

  // Mode selection bits written by software.
  typedef struct packed {
    logic standby_select;
    logic deep_sleep_enable;
    logic sub_power_mode_select;
    logic bus_output_hold;
    logic middle_speed_req;
  } lpm_ctrl_t;

  // Run enables for the blocks steered by the controller.
  typedef struct packed {
    logic cpu_clk_en;
    logic ram_en;
    logic dma_en;
    logic xfer_en;
    logic flash_en;
    logic main_wdt_en;
    logic timer8_en;
    logic periph_en;
    logic io_hold;
    logic bus_out_en;
    logic main_osc_en;
    logic fast_osc_en;
    logic slow_osc_en;
    logic main_pll_en;
    logic usb_pll_en;
    logic aon_en;
  } lpm_gate_t;
endpackage

//--- design/lpm_clk_div.sv
/*
 * One programmable clock divider producing a single-cycle enable strobe.
 * Assumes the division setting is synchronous to ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module lpm_clk_div
  import lpm_pkg::*;
#(
  parameter int unsigned W = DIV_W
) (
  input  wire logic         ref_clk_i,  // Reference clock.
  input  wire logic         sys_rst_i,  // Synchronous reset.
  input  wire logic         run_i,      // Divider may advance.
  input  wire logic [W-1:0] div_i,      // Divide by div_i + 1.
  output logic              tick_o      // One-cycle strobe.
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !run_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else if (cnt_ff >= div_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- design/lpm_ctrl.sv
/*
 * Low-power mode controller: clock dividers, operating power mode and
 * sleep, deep sleep and software standby sequencing.
 * Assumes the CPU pulses wait_exec_i for one cycle and services the
 * waking interrupt after wake_o; irq_i is synchronous to ref_clk_i.
 */
// Summary of operation
// - Six independently programmable clock division ratios.
// - Only high, middle and low operating modes.
// - Sleep, deep sleep, standby; nothing else.
// - Mode entered only on the wait instruction.
// - Interrupt ends mode; CPU runs its handler.
// - Low-power modes halt CPU, keeping its state.
// - Sleep keeps RAM accessible and preserved.
// - Sleep lets both transfer controllers run.
// - Sleep keeps flash and I/O ports running.
// - Main watchdog stopped in every low-power mode.
// - Deep sleep stops flash, RAM, transfer controllers.
// - Standby stops main, fast, slow oscillators, PLLs.
// - Standby stops timers, peripherals, RAM; pins hold.
// - Always-on modules keep running in every mode.
// - Power-on reset circuit runs in every mode.
// - Standby select picks standby over sleep types.
// - Deep sleep enable picks deep over plain sleep.
// - Sub-mode select bit picks low-speed operation.
// - Standby bus outputs float unless hold bit set.
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = OSC_SETTLE_CYC
) (
  input  wire logic                     ref_clk_i,   // Clock, 40 MHz.
  input  wire logic                     sys_rst_i,   // Sync reset.
  input  wire lpm_ctrl_t                ctrl_i,      // Mode select bits.
  input  wire logic [NUM_CLK*DIV_W-1:0] div_i,       // Division ratios.
  input  wire logic                     wait_exec_i, // Wait pulse.
  input  wire logic                     irq_i,       // Pending interrupt.
  output lpm_gate_t                     gate_o,      // Block enables.
  output lpm_op_mode_t                  op_mode_o,   // Operating mode.
  output logic [NUM_CLK-1:0]            clk_tick_o,  // Divided strobes.
  output logic                          wake_o,      // Wake pulse to CPU.
  output logic                          por_en_o,    // Power-on reset on.
  output logic [1:0]                    lp_state_o   // 0 run,1 slp,2 ds,3 sb.
);
  lpm_state_t   state_ff;
  lpm_state_t   nxt_state;
  lpm_gate_t    nxt_gate;
  lpm_op_mode_t nxt_op_mode;
  logic [$clog2(SETTLE_CYC+1)-1:0] settle_ff;
  logic [NUM_CLK-1:0] tick_w;

  function automatic lpm_gate_t gates_for(input lpm_state_t st,
                                          input logic       hold);
    lpm_gate_t g;
    g = '1;
    g.io_hold    = 1'b0;
    unique case (st)
      LPM_RUN, LPM_CLK_WAKE: begin
      end
      LPM_SLEEP: begin
        g.cpu_clk_en  = 1'b0;
        g.main_wdt_en = 1'b0;
      end
      LPM_DEEP_SLEEP: begin
        g.cpu_clk_en  = 1'b0;
        g.main_wdt_en = 1'b0;
        g.ram_en      = 1'b0;
        g.dma_en      = 1'b0;
        g.xfer_en     = 1'b0;
        g.flash_en    = 1'b0;
      end
      LPM_STANDBY, LPM_OSC_WAKE: begin
        g.cpu_clk_en  = 1'b0;
        g.main_wdt_en = 1'b0;
        g.ram_en      = 1'b0;
        g.dma_en      = 1'b0;
        g.xfer_en     = 1'b0;
        g.flash_en    = 1'b0;
        g.timer8_en   = 1'b0;
        g.periph_en   = 1'b0;
        g.io_hold     = 1'b1;
        g.bus_out_en  = hold;
        g.main_osc_en = (st == LPM_OSC_WAKE);
        g.fast_osc_en = (st == LPM_OSC_WAKE);
        g.slow_osc_en = (st == LPM_OSC_WAKE);
        g.main_pll_en = (st == LPM_OSC_WAKE);
        g.usb_pll_en  = (st == LPM_OSC_WAKE);
      end
    endcase
    g.aon_en = 1'b1;
    return g;
  endfunction

  // Sleep leaves RAM, flash, I/O and transfer engines running.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      LPM_RUN: begin
        if (wait_exec_i) begin
          if (ctrl_i.standby_select) begin
            nxt_state = LPM_STANDBY;
          end else if (ctrl_i.deep_sleep_enable) begin
            nxt_state = LPM_DEEP_SLEEP;
          end else begin
            nxt_state = LPM_SLEEP;
          end
        end
      end
      LPM_SLEEP, LPM_DEEP_SLEEP: begin
        if (irq_i) begin
          nxt_state = LPM_CLK_WAKE;
        end
      end
      LPM_STANDBY: begin
        if (irq_i) begin
          nxt_state = LPM_OSC_WAKE;
        end
      end
      LPM_OSC_WAKE: begin
        if (settle_ff == '0) begin
          nxt_state = LPM_CLK_WAKE;
        end
      end
      LPM_CLK_WAKE: begin
        nxt_state = LPM_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_ff <= LPM_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Oscillator settling count, loaded on standby exit.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      settle_ff <= '0;
    end else if (state_ff == LPM_STANDBY && irq_i) begin
      settle_ff <= ($clog2(SETTLE_CYC+1))'(SETTLE_CYC - 1);
    end else if (settle_ff != '0) begin
      settle_ff <= settle_ff - 1'b1;
    end
  end

  assign nxt_gate = gates_for(nxt_state, ctrl_i.bus_output_hold);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      gate_o <= gates_for(LPM_RUN, 1'b0);
    end else begin
      gate_o <= nxt_gate;
    end
  end

  // Wake pulse asks the CPU to take the interrupt, not fall through.
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= (state_ff == LPM_CLK_WAKE);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      lp_state_o <= 2'h0;
      por_en_o   <= 1'b1;
    end else begin
      por_en_o <= 1'b1;
      unique case (nxt_state)
        LPM_SLEEP:                 lp_state_o <= 2'h1;
        LPM_DEEP_SLEEP:            lp_state_o <= 2'h2;
        LPM_STANDBY, LPM_OSC_WAKE: lp_state_o <= 2'h3;
        default:                   lp_state_o <= 2'h0;
      endcase
    end
  end

  always_comb begin
    if (ctrl_i.sub_power_mode_select) begin
      nxt_op_mode = LPM_OP_LOW;
    end else if (ctrl_i.middle_speed_req) begin
      nxt_op_mode = LPM_OP_MIDDLE;
    end else begin
      nxt_op_mode = LPM_OP_HIGH;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      op_mode_o <= LPM_OP_HIGH;
    end else begin
      op_mode_o <= nxt_op_mode;
    end
  end

  // Each divider runs only while its domain is enabled.
  for (genvar i = 0; i < NUM_CLK; i++) begin : g_div
    logic run_w;
    assign run_w = (i == CLK_CORE) ? gate_o.cpu_clk_en :
                   (i == CLK_FLASH_IF) ? gate_o.flash_en :
                   gate_o.periph_en;
    lpm_clk_div #(.W(DIV_W)) u_div (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .run_i     (run_w),
      .div_i     (div_i[i*DIV_W +: DIV_W]),
      .tick_o    (tick_w[i])
    );
  end
  assign clk_tick_o = tick_w;

  a_no_spont_entry: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_ff == LPM_RUN && !wait_exec_i) |=> gate_o.cpu_clk_en)
    else $error("entry without wait");
  a_standby_sel: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_ff == LPM_RUN && wait_exec_i && ctrl_i.standby_select) |=>
    (lp_state_o == 2'h3 && !gate_o.main_osc_en))
    else $error("standby not entered");
  a_deep_sel: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_ff == LPM_RUN && wait_exec_i && !ctrl_i.standby_select &&
    ctrl_i.deep_sleep_enable) |=> (lp_state_o == 2'h2 && !gate_o.ram_en))
    else $error("deep sleep wrong");
  a_sleep_ram: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    lp_state_o == 2'h1 |-> (gate_o.ram_en && gate_o.dma_en &&
    gate_o.flash_en && !gate_o.cpu_clk_en))
    else $error("sleep gating wrong");
  a_wdt_stop: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    lp_state_o != 2'h0 |-> !gate_o.main_wdt_en)
    else $error("watchdog running");
  a_bus_hold: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_ff == LPM_STANDBY) |->
    (gate_o.bus_out_en == $past(ctrl_i.bus_output_hold)))
    else $error("bus hold");
  sequence s_sleep_irq;
    (state_ff == LPM_SLEEP || state_ff == LPM_DEEP_SLEEP) && irq_i;
  endsequence
  a_sleep_wake: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    s_sleep_irq |=> ##1 (wake_o && gate_o.cpu_clk_en))
    else $error("sleep wake late");
  a_osc_first: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (state_ff == LPM_STANDBY && irq_i) |=>
    (gate_o.main_osc_en && !gate_o.cpu_clk_en))
    else $error("osc order");
  a_low_mode: assert property (
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ctrl_i.sub_power_mode_select |=> op_mode_o == LPM_OP_LOW)
    else $error("low speed mode");
endmodule
`default_nettype wire

//--- dv/lpm_cpu_model.sv
/*
 * Behavioural CPU core facing the low-power controller.
 * Assumes the controller samples wait and interrupt on ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module lpm_cpu_model (
  input  wire logic ref_clk_i,   // Clock.
  input  wire logic wake_i,      // Wake pulse from controller.
  output logic      wait_exec_o, // Wait instruction executed.
  output logic      irq_o        // Interrupt pending.
);
  initial begin
    wait_exec_o = 1'b0;
    irq_o = 1'b0;
  end
  task automatic exec_wait();
    @(posedge ref_clk_i);
    #1 wait_exec_o = 1'b1;
    @(posedge ref_clk_i);
    #1 wait_exec_o = 1'b0;
  endtask
  // The interrupt stays pending until the wake pulse is seen or limit cycles pass.
  task automatic take_irq(input int limit, output int lat);
    lat = 0;
    @(posedge ref_clk_i);
    #1 irq_o = 1'b1;
    while (lat < limit) begin
      @(posedge ref_clk_i);
      #1 lat++;
      if (wake_i === 1'b1) break;
    end
    irq_o = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- dv/lpm_ctrl_test.sv
/*
 * Self-checking bench for the low-power mode controller.
 * Assumes the behavioural CPU model drives wait and interrupt.
 */
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_test;
  import lpm_pkg::*;
  localparam int SETTLE = 2;
  localparam int LIMIT  = 20000;
  typedef struct packed {
    logic [1:0] st;
    lpm_gate_t  g;
  } lpm_note_t;
  logic                     ref_clk_i = 1'b0;
  logic                     sys_rst_i = 1'b1;
  lpm_ctrl_t                ctrl_i = '0;
  logic [NUM_CLK*DIV_W-1:0] div_i = '0;
  logic                     wait_exec;
  logic                     irq;
  lpm_gate_t                gate_o;
  lpm_op_mode_t             op_mode_o;
  logic [NUM_CLK-1:0]       clk_tick_o;
  logic                     wake_o;
  logic                     por_en_o;
  logic [1:0]               lp_state_o;
  lpm_note_t                notes[$];
  lpm_note_t                nt;
  logic [1:0]               last_st = 2'h0;
  int                       failures = 0;
  int                       tests_run = 0;
  int                       cyc = 0;
  int                       lat;
  int unsigned              seed;
  logic [3:0]               d [NUM_CLK];

  lpm_ctrl #(.SETTLE_CYC(SETTLE)) u_dut (
    .ref_clk_i   (ref_clk_i),
    .sys_rst_i   (sys_rst_i),
    .ctrl_i      (ctrl_i),
    .div_i       (div_i),
    .wait_exec_i (wait_exec),
    .irq_i       (irq),
    .gate_o      (gate_o),
    .op_mode_o   (op_mode_o),
    .clk_tick_o  (clk_tick_o),
    .wake_o      (wake_o),
    .por_en_o    (por_en_o),
    .lp_state_o  (lp_state_o)
  );
  lpm_cpu_model u_cpu (
    .ref_clk_i   (ref_clk_i),
    .wake_i      (wake_o),
    .wait_exec_o (wait_exec),
    .irq_o       (irq)
  );

  always #12.5 ref_clk_i = ~ref_clk_i;

  task automatic results();
    if (failures == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic lpm_gate_t exp_gate(input logic [1:0] st,
                                         input logic hold);
    lpm_gate_t g;
    g = '1;
    g.io_hold = 1'b0;
    if (st != 2'h0) begin
      g.cpu_clk_en = 1'b0;
      g.main_wdt_en = 1'b0;
    end
    if (st >= 2'h2) begin
      {g.ram_en, g.dma_en, g.xfer_en, g.flash_en} = 4'h0;
    end
    if (st == 2'h3) begin
      {g.timer8_en, g.periph_en, g.io_hold} = 3'h1;
      {g.main_osc_en, g.fast_osc_en, g.slow_osc_en} = 3'h0;
      {g.main_pll_en, g.usb_pll_en} = 2'h0;
      g.bus_out_en = hold;
    end
    return g;
  endfunction

  // A change of mode is only legal where the driver noted one.
  always @(negedge ref_clk_i) begin
    if (sys_rst_i)
      last_st = 2'h0;
    else if (lp_state_o !== last_st) begin
      if (notes.size() == 0)
        check(32'(lp_state_o), 32'(last_st), "unnoted change");
      else begin
        nt = notes.pop_front();
        check(32'({lp_state_o, gate_o}), 32'(nt), "mode gates");
      end
      last_st = lp_state_o;
    end
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      results();
    end
  end

  task automatic lp_cycle(input lpm_ctrl_t c, input logic [1:0] st);
    int exp_lat;
    @(posedge ref_clk_i);
    #1 ctrl_i = c;
    repeat (3) @(posedge ref_clk_i);
    notes.push_back({st, exp_gate(st, c.bus_output_hold)});
    u_cpu.exec_wait();
    repeat (2) @(posedge ref_clk_i);
    #1 check(32'(por_en_o), 32'h1, "por");
    u_cpu.exec_wait();
    notes.push_back({2'h0, exp_gate(2'h0, 1'b0)});
    u_cpu.take_irq(60, lat);
    // Wake pulse follows the irq edge by two cycles, plus settling.
    exp_lat = (st == 2'h3) ? SETTLE + 2 : 2;
    check(32'(lat), 32'(exp_lat), "wake");
    @(posedge ref_clk_i);
    #1 check(32'(wake_o), 32'h0, "wake length");
  endtask

  initial begin
    lpm_ctrl_t    c;
    lpm_op_mode_t om;
    lpm_note_t    r;
    seed = $urandom(32'h09183602);
    repeat (8) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    r = {2'h0, exp_gate(2'h0, 1'b0)};
    check(32'({lp_state_o, gate_o}), 32'(r), "reset");
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      #1 ctrl_i.sub_power_mode_select = i[1];
      ctrl_i.middle_speed_req = i[0];
      repeat (2) @(posedge ref_clk_i);
      #1 om = i[1] ? LPM_OP_LOW : (i[0] ? LPM_OP_MIDDLE : LPM_OP_HIGH);
      check(32'(op_mode_o), 32'(om), "op mode");
    end
    for (int k = 0; k < NUM_CLK; k++) begin
      d[k] = 4'($urandom_range(15));
      div_i[k*DIV_W +: DIV_W] = d[k];
    end
    for (int k = 0; k < NUM_CLK; k++) begin
      for (int n = 0; n < 3; n++) begin
        lat = 0;
        do begin
          @(posedge ref_clk_i);
          #1 lat++;
        end while (clk_tick_o[k] !== 1'b1 && lat < 40);
      end
      check(32'(lat), 32'(d[k]) + 32'h1, "divider period");
    end
    u_cpu.take_irq(4, lat);
    check(32'(lat), 32'h4, "irq in run");
    for (int m = 0; m < 4; m++) begin
      c = '0;
      c.standby_select = m[1];
      c.deep_sleep_enable = m[1] ? 1'($urandom) : m[0];
      c.bus_output_hold = m[1] ? m[0] : 1'($urandom);
      lp_cycle(c, m[1] ? 2'h3 : (m[0] ? 2'h2 : 2'h1));
    end
    repeat (4) @(posedge ref_clk_i);
    check(32'(notes.size()), 32'h0, "pending notes");
    results();
  end
endmodule
`default_nettype wire
